// ---- hw/device_config_register_bank.sv ----
/*
  Device configuration register bank behind an APB slave: interrupt
  summary and codes, timer settings, per-channel sampling, soft-reset
  and sleep bytes, identity bytes, EEPROM control, pin control bytes.
  Assumes UART requests, codes and events come from pclk logic.
  Each channel window repeats the bank every 0x400 bytes.
*/
`timescale 1ns/1ns
`include "cfg_bank_defs.svh"
module device_config_register_bank #(
  parameter int ADDR_W = 14,
  parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] IDENT_CODE = 8'h5A // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] uart_irq_req,
  input wire logic [23:0] uart_irq_code,
  input wire logic timer_event,
  input wire logic pin_event,
  output logic irq,
  output cfg_bank_pkg::cfg_byte_t timer_control,
  output logic [15:0] timer_value,
  output cfg_bank_pkg::cfg_byte_t eight_times_sampling,
  output cfg_bank_pkg::cfg_byte_t four_times_sampling,
  output cfg_bank_pkg::cfg_byte_t channel_soft_reset,
  output cfg_bank_pkg::cfg_byte_t channel_sleep_enable,
  output cfg_bank_pkg::cfg_byte_t eeprom_control,
  output logic [15:0] pin_irq_mask,
  output logic [15:0] pin_level,
  output logic [15:0] pin_output_ctl,
  output logic [15:0] pin_polarity,
  output logic [15:0] pin_function,
  output logic [15:0] pin_open_drain
);
  import cfg_bank_pkg::*;

  cfg_irq_if irq_bus ();

  apb_state_t state_r;
  logic wr_go;
  logic rd_go;
  logic mapped;
  chan_idx_t chan;
  cfg_byte_t chan_bit;
  cfg_byte_t low_off;
  logic [31:0] rd_word;
  cfg_byte_t sleep_prev_r;

  ////////////////////////////////////////////////////////////////////
  // Address decode helpers
  function automatic logic in_window(input logic [ADDR_W-1:0] a);
    in_window = (a[ADDR_W-1:13] == '0) && (a[9:8] == 2'b00);
  endfunction

  function automatic logic word_hit(input logic [ADDR_W-1:0] a, input cfg_byte_t off);
    word_hit = in_window(a) && (a[7:2] == off[7:2]);
  endfunction

  // One byte lane of the current write
  function automatic logic byte_we(input cfg_byte_t off);
    byte_we = wr_go && word_hit(paddr, off) && pstrb[off[1:0]];
  endfunction

  function automatic cfg_byte_t lane(input logic [31:0] w, input cfg_byte_t off);
    lane = w[{off[1:0], 3'b000} +: 8];
  endfunction

  // Only the issuing channel's bit changes
  function automatic cfg_byte_t chan_merge(input cfg_byte_t old, input cfg_byte_t nw,
                                           input cfg_byte_t m);
    chan_merge = (old & ~m) | (nw & m);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer on the second access cycle
  assign low_off = {paddr[7:2], 2'b00};
  assign mapped = in_window(paddr) &&
    ((low_off >= `OFF_IRQ_SUMMARY && low_off <= `OFF_PIN_POL_HI) ||
     low_off == `OFF_EVT_STATUS || low_off == `OFF_EVT_MASK);
  assign wr_go = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && pready && !pwrite;
  assign chan = paddr[12:10];
  assign chan_bit = 8'h01 << chan;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (psel && penable)
            state_r <= ST_ANSWER;
        ST_ANSWER:
          state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= (state_r == ST_IDLE) && psel && penable;
      pslverr <= (state_r == ST_IDLE) && psel && penable && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, reserved and write-only bytes read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (mapped)
    begin
      unique case (low_off)
        `OFF_IRQ_SUMMARY: rd_word = irq_bus.int_word;
        `OFF_TIMER_CTL: rd_word = {timer_value, 8'h00, timer_control};
        `OFF_SAMPLE_8X: rd_word = {channel_sleep_enable, 8'h00,
                                   four_times_sampling, eight_times_sampling};
        `OFF_REVISION: rd_word = {pin_irq_mask[7:0], eeprom_control,
                                  IDENT_CODE, REVISION_CODE};
        `OFF_PIN_LEVEL_LO: rd_word = {pin_function[7:0], pin_polarity[7:0],
                                      pin_output_ctl[7:0], pin_level[7:0]};
        `OFF_PIN_OD_LO: rd_word = {pin_output_ctl[15:8], pin_level[15:8],
                                   pin_irq_mask[15:8], pin_open_drain[7:0]};
        `OFF_PIN_POL_HI: rd_word = {8'h00, pin_open_drain[15:8],
                                    pin_function[15:8], pin_polarity[15:8]};
        `OFF_EVT_STATUS: rd_word = {24'h00_0000, irq_bus.status};
        `OFF_EVT_MASK: rd_word = {24'h00_0000, irq_bus.mask};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if ((state_r == ST_IDLE) && psel && penable && !pwrite)
      prdata <= rd_word;
  end

  ////////////////////////////////////////////////////////////////////
  // Timer settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_control <= `RST_BYTE_ZERO;
    else if (byte_we(`OFF_TIMER_CTL))
      timer_control <= lane(pwdata, `OFF_TIMER_CTL);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_value <= {`RST_BYTE_ZERO, `RST_BYTE_ZERO};
    else
    begin
      if (byte_we(`OFF_TIMER_LOW))
        timer_value[7:0] <= lane(pwdata, `OFF_TIMER_LOW);
      if (byte_we(`OFF_TIMER_HIGH))
        timer_value[15:8] <= lane(pwdata, `OFF_TIMER_HIGH);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-channel sampling, soft-reset and sleep bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eight_times_sampling <= `RST_BYTE_ZERO;
    else if (byte_we(`OFF_SAMPLE_8X))
      eight_times_sampling <= chan_merge(eight_times_sampling,
                                         lane(pwdata, `OFF_SAMPLE_8X), chan_bit);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      four_times_sampling <= `RST_BYTE_ZERO;
    else if (byte_we(`OFF_SAMPLE_4X))
      four_times_sampling <= chan_merge(four_times_sampling,
                                        lane(pwdata, `OFF_SAMPLE_4X), chan_bit);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_sleep_enable <= `RST_BYTE_ZERO;
    else if (byte_we(`OFF_SLEEP))
      channel_sleep_enable <= chan_merge(channel_sleep_enable,
                                         lane(pwdata, `OFF_SLEEP), chan_bit);
  end

  // Reset bit stands one cycle as the channel reset, then clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_soft_reset <= `RST_BYTE_ZERO;
    else if (byte_we(`OFF_SOFT_RESET))
      channel_soft_reset <= lane(pwdata, `OFF_SOFT_RESET) & chan_bit;
    else
      channel_soft_reset <= `RST_BYTE_ZERO;
  end

  ////////////////////////////////////////////////////////////////////
  // Wake: all channels asleep, then any leaves sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep_prev_r <= `RST_BYTE_ZERO;
    else
      sleep_prev_r <= channel_sleep_enable;
  end

  ////////////////////////////////////////////////////////////////////
  // EEPROM control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eeprom_control <= `RST_BYTE_ZERO;
    else if (byte_we(`OFF_EEPROM))
      eeprom_control <= lane(pwdata, `OFF_EEPROM);
  end

  ////////////////////////////////////////////////////////////////////
  // Pin control bytes, low and high halves
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_irq_mask <= {`RST_BYTE_ZERO, `RST_BYTE_ZERO};
    else
    begin
      if (byte_we(`OFF_PIN_MASK_LO))
        pin_irq_mask[7:0] <= lane(pwdata, `OFF_PIN_MASK_LO);
      if (byte_we(`OFF_PIN_MASK_HI))
        pin_irq_mask[15:8] <= lane(pwdata, `OFF_PIN_MASK_HI);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_level <= {`RST_BYTE_ZERO, `RST_BYTE_ZERO};
    else
    begin
      if (byte_we(`OFF_PIN_LEVEL_LO))
        pin_level[7:0] <= lane(pwdata, `OFF_PIN_LEVEL_LO);
      if (byte_we(`OFF_PIN_LEVEL_HI))
        pin_level[15:8] <= lane(pwdata, `OFF_PIN_LEVEL_HI);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_output_ctl <= {`RST_BYTE_ZERO, `RST_BYTE_ZERO};
    else
    begin
      if (byte_we(`OFF_PIN_OUT_LO))
        pin_output_ctl[7:0] <= lane(pwdata, `OFF_PIN_OUT_LO);
      if (byte_we(`OFF_PIN_OUT_HI))
        pin_output_ctl[15:8] <= lane(pwdata, `OFF_PIN_OUT_HI);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_polarity <= {`RST_BYTE_ZERO, `RST_BYTE_ZERO};
    else
    begin
      if (byte_we(`OFF_PIN_POL_LO))
        pin_polarity[7:0] <= lane(pwdata, `OFF_PIN_POL_LO);
      if (byte_we(`OFF_PIN_POL_HI))
        pin_polarity[15:8] <= lane(pwdata, `OFF_PIN_POL_HI);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_open_drain <= {`RST_BYTE_ZERO, `RST_BYTE_ZERO};
    else
    begin
      if (byte_we(`OFF_PIN_OD_LO))
        pin_open_drain[7:0] <= lane(pwdata, `OFF_PIN_OD_LO);
      if (byte_we(`OFF_PIN_OD_HI))
        pin_open_drain[15:8] <= lane(pwdata, `OFF_PIN_OD_HI);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_function <= {`RST_PIN_FUNC, `RST_PIN_FUNC};
    else
    begin
      if (byte_we(`OFF_PIN_FUNC_LO))
        pin_function[7:0] <= lane(pwdata, `OFF_PIN_FUNC_LO);
      if (byte_we(`OFF_PIN_FUNC_HI))
        pin_function[15:8] <= lane(pwdata, `OFF_PIN_FUNC_HI);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt unit hookup
  assign irq_bus.uart_req = uart_irq_req;
  assign irq_bus.uart_code = uart_irq_code;
  assign irq_bus.timer_evt = timer_event;
  assign irq_bus.pin_evt = pin_event;
  assign irq_bus.wake_evt = (sleep_prev_r == `ALL_ASLEEP) &&
                            (channel_sleep_enable != `ALL_ASLEEP);
  assign irq_bus.summary_rd = rd_go && word_hit(paddr, `OFF_IRQ_SUMMARY);
  // Bus terms spelled out: a call with constant arguments alone never re-evaluates
  assign irq_bus.status_clr_we = wr_go && word_hit(paddr, `OFF_EVT_STATUS) && pstrb[0];
  assign irq_bus.mask_we = wr_go && word_hit(paddr, `OFF_EVT_MASK) && pstrb[0];
  assign irq_bus.wdata = pwdata[7:0];

  cfg_irq_unit u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .port(irq_bus.unit)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= irq_bus.irq;
  end
endmodule

// ---- hw/cfg_bank_defs.svh ----
/*
  Offsets, field positions, reset values and interrupt codes of the
  device configuration bank.
  Assumes a 32-bit APB with byte strobes; included by bare name.
*/
// Behaviour
// - channel window writes only its own mode bit
// - soft-reset byte write-only, bits self-clear
// - sixteen pin interrupt mask bits, reset zero
// - sixteen pin level bits, reset zero
// - sixteen pin output enable bits, reset zero
// - sixteen pin polarity bits, reset zero
// - sixteen pin open-drain bits, reset zero
// - bytes reachable singly or packed in words
// - timer control plus 16-bit value, reset zero
// - four interrupt bytes read-only, one word
// - fixed revision and id, eeprom byte RW
// - pin function bytes reset to all ones
// - summary bit n set while channel n requests
// - 3-bit code per channel, globals in channel 0
// - wake event cleared by summary byte read
`ifndef CFG_BANK_DEFS_SVH
`define CFG_BANK_DEFS_SVH

`define OFF_IRQ_SUMMARY 8'h80
`define OFF_IRQ_CODE1 8'h81
`define OFF_TIMER_CTL 8'h84
`define OFF_RSVD_A 8'h85
`define OFF_TIMER_LOW 8'h86
`define OFF_TIMER_HIGH 8'h87
`define OFF_SAMPLE_8X 8'h88
`define OFF_SAMPLE_4X 8'h89
`define OFF_SOFT_RESET 8'h8A
`define OFF_SLEEP 8'h8B
`define OFF_REVISION 8'h8C
`define OFF_IDENT 8'h8D
`define OFF_EEPROM 8'h8E
`define OFF_PIN_MASK_LO 8'h8F
`define OFF_PIN_LEVEL_LO 8'h90
`define OFF_PIN_OUT_LO 8'h91
`define OFF_PIN_POL_LO 8'h92
`define OFF_PIN_FUNC_LO 8'h93
`define OFF_PIN_OD_LO 8'h94
`define OFF_PIN_MASK_HI 8'h95
`define OFF_PIN_LEVEL_HI 8'h96
`define OFF_PIN_OUT_HI 8'h97
`define OFF_PIN_POL_HI 8'h98
`define OFF_PIN_FUNC_HI 8'h99
`define OFF_PIN_OD_HI 8'h9A
`define OFF_RSVD_TAIL 8'h9B
`define OFF_EVT_STATUS 8'hA0
`define OFF_EVT_MASK 8'hA4

`define RST_BYTE_ZERO 8'h00
`define RST_PIN_FUNC 8'hFF

`define EVT_BIT_WAKE 0
`define EVT_BIT_TIMER 1
`define EVT_BIT_PIN 2

`define CODE_NONE 3'h0
`define CODE_PIN 3'h6
`define CODE_TIMER 3'h7

`define ALL_ASLEEP 8'hFF

`endif

// ---- hw/cfg_bank_pkg.sv ----
/*
  Types shared by the configuration bank and its interrupt unit.
  Assumes the constants header is included where offsets are needed.
*/
package cfg_bank_pkg;
  typedef logic [7:0] cfg_byte_t;
  typedef logic [2:0] chan_idx_t;
  typedef logic [2:0] irq_code_t;
  typedef enum logic {ST_IDLE, ST_ANSWER} apb_state_t;
endpackage

// ---- hw/cfg_irq_if.sv ----
/*
  Carrier between the register bank and its interrupt unit.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ns
interface cfg_irq_if;
  import cfg_bank_pkg::*;
  logic [7:0] uart_req;
  logic [23:0] uart_code;
  logic timer_evt;
  logic pin_evt;
  logic wake_evt;
  logic summary_rd;
  logic status_clr_we;
  logic mask_we;
  cfg_byte_t wdata;
  cfg_byte_t status;
  cfg_byte_t mask;
  logic [31:0] int_word;
  logic irq;
  modport bank (
    output uart_req, uart_code, timer_evt, pin_evt, wake_evt, summary_rd,
    output status_clr_we, mask_we, wdata,
    input status, mask, int_word, irq
  );
  modport unit (
    input uart_req, uart_code, timer_evt, pin_evt, wake_evt, summary_rd,
    input status_clr_we, mask_we, wdata,
    output status, mask, int_word, irq
  );
endinterface

// ---- hw/cfg_irq_unit.sv ----
/*
  Sticky event status, mask, interrupt output and the packed
  interrupt summary/code word.
  Assumes request and code inputs are synchronous to pclk.
*/
`timescale 1ns/1ns
`include "cfg_bank_defs.svh"
module cfg_irq_unit (
  input wire logic pclk,
  input wire logic presetn,
  cfg_irq_if.unit port
);
  import cfg_bank_pkg::*;

  cfg_byte_t status_r;
  cfg_byte_t mask_r;
  logic [31:0] int_word_r;
  logic irq_r;
  cfg_byte_t set_vec;
  cfg_byte_t clr_vec;
  irq_code_t chan0_code;

  assign port.status = status_r;
  assign port.mask = mask_r;
  assign port.int_word = int_word_r;
  assign port.irq = irq_r;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`EVT_BIT_WAKE] = port.wake_evt;
    set_vec[`EVT_BIT_TIMER] = port.timer_evt;
    set_vec[`EVT_BIT_PIN] = port.pin_evt;
    clr_vec = port.status_clr_we ? port.wdata : 8'h00;
    clr_vec[`EVT_BIT_WAKE] = clr_vec[`EVT_BIT_WAKE] | port.summary_rd;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= `RST_BYTE_ZERO;
    else
      status_r <= (status_r & ~clr_vec) | set_vec;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= `RST_BYTE_ZERO;
    else if (port.mask_we)
      mask_r <= port.wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(status_r & mask_r);
  end

  ////////////////////////////////////////////////////////////////////
  // Channel code first, then pin, then timer; wake reads as none
  always_comb
  begin
    if (port.uart_code[2:0] != `CODE_NONE)
      chan0_code = port.uart_code[2:0];
    else if (status_r[`EVT_BIT_PIN])
      chan0_code = `CODE_PIN;
    else if (status_r[`EVT_BIT_TIMER])
      chan0_code = `CODE_TIMER;
    else
      chan0_code = `CODE_NONE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_word_r <= 32'h0000_0000;
    else
    begin
      int_word_r[7:1] <= port.uart_req[7:1];
      int_word_r[0] <= port.uart_req[0] | (|status_r[2:0]);
      int_word_r[31:11] <= port.uart_code[23:3];
      int_word_r[10:8] <= chan0_code;
    end
  end
endmodule

// ---- verif/cfg_bank_asserts.sv ----
/*
  Concurrent checks on the ports of the configuration bank.
  Assumes one pclk domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module cfg_bank_asserts import cfg_bank_pkg::*; #(
  parameter int ADDR_W = 14,
  parameter logic [7:0] REVISION_CODE = 8'h01,
  parameter logic [7:0] IDENT_CODE = 8'h5A
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] uart_irq_req,
  input wire logic [15:0] timer_value,
  input wire cfg_bank_pkg::cfg_byte_t eight_times_sampling,
  input wire cfg_bank_pkg::cfg_byte_t channel_soft_reset,
  input wire cfg_bank_pkg::cfg_byte_t channel_sleep_enable,
  input wire logic [15:0] pin_level,
  input wire logic [15:0] pin_function
);
  logic rd;
  logic [5:0] wd;
  assign rd = pready && !pwrite && !pslverr;
  assign wd = paddr[7:2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_chan;
    pready && pwrite && !pslverr && wd == 6'h22 |=>
      (({channel_sleep_enable, eight_times_sampling} ^
        $past({channel_sleep_enable, eight_times_sampling})) &
       ~{2{8'h01 << $past(paddr[12:10])}}) == 16'h0000;
  endproperty
  a_chan: assert property (p_chan) else $error("other channel bit changed");
  property p_sr_self; channel_soft_reset != 8'h00 |=> channel_soft_reset == 8'h00; endproperty
  a_sr_self: assert property (p_sr_self) else $error("soft reset not cleared");
  property p_sr_read; rd && wd == 6'h22 |-> prdata[23:16] == 8'h00; endproperty
  a_sr_read: assert property (p_sr_read) else $error("soft reset byte readable");
  property p_ident; rd && wd == 6'h23 |-> prdata[15:0] == {IDENT_CODE, REVISION_CODE}; endproperty
  a_ident: assert property (p_ident) else $error("identity bytes wrong");
  property p_rsvd;
    rd |-> (wd != 6'h21 || prdata[15:8] == 8'h00) && (wd != 6'h26 || prdata[31:24] == 8'h00);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
  property p_unmapped; pready && paddr[ADDR_W-1] |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_rst;
    $rose(presetn) |-> pin_function == 16'hFFFF && pin_level == 16'h0000 &&
      timer_value == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_summary;
    rd && !paddr[ADDR_W-1] && wd == 6'h20 && uart_irq_req == $past(uart_irq_req, 3) |->
      prdata[7:1] == uart_irq_req[7:1];
  endproperty
  a_summary: assert property (p_summary) else $error("summary bits wrong");
endmodule
////////////////////////////////////////
bind device_config_register_bank cfg_bank_asserts #(.ADDR_W(ADDR_W),
  .REVISION_CODE(REVISION_CODE), .IDENT_CODE(IDENT_CODE)) u_cfg_bank_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .uart_irq_req(uart_irq_req), .timer_value(timer_value),
  .eight_times_sampling(eight_times_sampling), .channel_soft_reset(channel_soft_reset),
  .channel_sleep_enable(channel_sleep_enable), .pin_level(pin_level),
  .pin_function(pin_function));

// ---- verif/device_config_register_bank_tb.sv ----
/*
  Self-checking bench of the configuration bank over APB.
  Assumes the checker file is compiled alongside for the bind.
*/
`timescale 1ns/1ns
`include "cfg_bank_defs.svh"
module device_config_register_bank_tb;
  import cfg_bank_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  localparam logic [7:0] ID = 8'hC3; // Arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic timer_event, pin_event;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] uart_irq_req;
  logic [23:0] uart_irq_code;
  cfg_byte_t timer_control, eight_times_sampling, four_times_sampling, channel_soft_reset;
  cfg_byte_t channel_sleep_enable, eeprom_control;
  cfg_byte_t sr_seen = 8'h00;
  logic [15:0] timer_value, pin_irq_mask, pin_level, pin_output_ctl, pin_polarity;
  logic [15:0] pin_function, pin_open_drain;
  int bad_count = 0;
  int n_tests = 0;
  device_config_register_bank #(.REVISION_CODE(REV), .IDENT_CODE(ID))
    u_device_config_register_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uart_irq_req(uart_irq_req), .uart_irq_code(uart_irq_code),
    .timer_event(timer_event), .pin_event(pin_event), .irq(irq),
    .timer_control(timer_control), .timer_value(timer_value),
    .eight_times_sampling(eight_times_sampling), .four_times_sampling(four_times_sampling),
    .channel_soft_reset(channel_soft_reset), .channel_sleep_enable(channel_sleep_enable),
    .eeprom_control(eeprom_control), .pin_irq_mask(pin_irq_mask), .pin_level(pin_level),
    .pin_output_ctl(pin_output_ctl), .pin_polarity(pin_polarity),
    .pin_function(pin_function), .pin_open_drain(pin_open_drain));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (channel_soft_reset !== 8'h00) sr_seen <= channel_soft_reset;
  ////////////////////////////////////////
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [13:0] ad(input int ch, input logic [7:0] off);
    return {1'b0, ch[2:0], 2'b00, off};
  endfunction
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      chk("pready", 32'h0, 32'h1);
      end_sim();
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask
  task automatic rdw(input logic [13:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic wait3();
    repeat (3) @(posedge pclk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] e [7];
    e = '{32'h0, 32'h0, 32'h0, {16'h0, ID, REV}, 32'hFF000000, 32'h0, 32'h0000FF00};
    for (int i = 0; i < 7; i++)
    begin
      rdw(ad(0, 8'h80 + 8'(4 * i)));
      chk("reset word", rd, e[i]);
    end
    $display("reset test done");
  endtask
  task automatic t_rw();
    wr(ad(0, `OFF_TIMER_CTL), 32'hA1B2C3D4, 4'hF);
    wr(ad(0, `OFF_TIMER_CTL), 32'h00770000, 4'h4);
    rdw(ad(0, `OFF_TIMER_CTL));
    chk("timer word", rd, 32'hA17700D4);
    chk("timer ports", {8'h0, timer_value, timer_control}, 32'h00A177D4);
    wr(ad(0, `OFF_REVISION), 32'hFFFFFFFF, 4'hF);
    wr(ad(0, `OFF_PIN_LEVEL_LO), 32'h11223344, 4'hF);
    wr(ad(0, `OFF_PIN_OD_LO), 32'h55667788, 4'hF);
    wr(ad(0, `OFF_PIN_POL_HI), 32'hFFFFFFFF, 4'hF);
    rdw(ad(0, `OFF_REVISION));
    chk("ancillary2 word", rd, {16'hFFFF, ID, REV});
    chk("eeprom port", {24'h0, eeprom_control}, 32'hFF);
    rdw(ad(0, `OFF_PIN_LEVEL_LO));
    chk("pin word 1", rd, 32'h11223344);
    rdw(ad(0, `OFF_PIN_OD_LO));
    chk("pin word 2", rd, 32'h55667788);
    rdw(ad(0, `OFF_PIN_POL_HI));
    chk("pin word 3", rd, 32'h00FFFFFF);
    chk("level out", {pin_level, pin_output_ctl}, 32'h66445533);
    chk("pol od", {pin_polarity, pin_open_drain}, 32'hFF22FF88);
    chk("func mask", {pin_function, pin_irq_mask}, 32'hFF1177FF);
    $display("read write test done");
  endtask
  task automatic t_chan();
    logic [7:0] m;
    for (int c = 0; c < 8; c++)
    begin
      wr(ad(c, `OFF_SAMPLE_8X), 32'hFFFFFFFF, 4'hB);
      @(posedge pclk);
      m = 8'((16'h2 << c) - 16'h1);
      chk("mode bytes", {8'h0, eight_times_sampling, four_times_sampling,
        channel_sleep_enable}, {8'h0, m, m, m});
    end
    wr(ad(3, `OFF_SAMPLE_8X), 32'h0, 4'hB);
    wr(ad(5, `OFF_SOFT_RESET), 32'h00FF0000, 4'h4);
    wait3();
    chk("soft reset pulse", {24'h0, sr_seen}, 32'h20);
    chk("soft reset idle", {24'h0, channel_soft_reset}, 32'h0);
    rdw(ad(0, `OFF_SAMPLE_8X));
    chk("ancillary1 word", rd, 32'hF700F7F7);
    rdw(ad(0, `OFF_IRQ_SUMMARY));
    chk("wake summary", rd, 32'h1);
    rdw(ad(0, `OFF_IRQ_SUMMARY));
    chk("wake cleared", rd, 32'h0);
    $display("channel test done");
  endtask
  task automatic t_events();
    @(posedge pclk);
    timer_event <= 1'b1;
    @(posedge pclk);
    timer_event <= 1'b0;
    wait3();
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdw(ad(0, `OFF_IRQ_SUMMARY));
    chk("timer code", rd, 32'h701);
    wr(ad(0, `OFF_EVT_MASK), 32'h2, 4'hF);
    wait3();
    chk("irq timer", {31'h0, irq}, 32'h1);
    @(posedge pclk);
    pin_event <= 1'b1;
    @(posedge pclk);
    pin_event <= 1'b0;
    wait3();
    rdw(ad(0, `OFF_IRQ_SUMMARY));
    chk("pin code", rd, 32'h601);
    wr(ad(0, `OFF_EVT_STATUS), 32'h2, 4'hF);
    wait3();
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rdw(ad(0, `OFF_EVT_STATUS));
    chk("event status", rd, 32'h4);
    wr(ad(0, `OFF_EVT_STATUS), 32'h4, 4'hF);
    uart_irq_req <= 8'hA5;
    uart_irq_code <= 24'h123456;
    wait3();
    rdw(ad(0, `OFF_IRQ_SUMMARY));
    chk("uart word", rd, 32'h123456A5);
    $display("event test done");
  endtask
  task automatic t_unmapped();
    rdw(14'h2080);
    chk("unmapped read", {err, rd[30:0]}, 32'h80000000);
    wr(14'h2090, 32'h0, 4'hF);
    @(posedge pclk);
    chk("unmapped write", {err, 15'h0, pin_level}, 32'h80006644);
    $display("unmapped test done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, presetn, timer_event, pin_event} = 6'h0;
    paddr = 14'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    uart_irq_req = 8'h0;
    uart_irq_code = 24'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rw();
    t_chan();
    t_events();
    t_unmapped();
    end_sim();
  end
endmodule
